//--- timer_reload_capture.sv
// 16-bit / dual 8-bit auto-reload timer with period capture
//
// Overview of operation
// - counter is 16 bits: low and high bytes, both software readable and writable
// - split bit 3 of control: 0 one 16-bit reload timer, 1 two 8-bit
// - rtc/8 input and comparator output pass a synchroniser before use
// - 16-bit rollover from all ones loads reload value, sets high flag
// - 16-bit mode: timer irq enable requests interrupt on every overflow
// - 16-bit mode: low-byte irq enable adds interrupt on low byte rollover
// - split mode: each byte reloads from its own reload byte on overflow
// - split mode: run bit gates high byte only; low byte always counts
// - per-byte clock select: core clock, else div12, rtc/8, comparator
// - split mode: high rollover sets high flag, low rollover sets low flag
// - split mode: irq on high overflow, also low when low-byte irq enabled
// - flags cleared only by software; software reads both to find source
// - capture-enable bit selects capture mode; clearing restores reload mode
// - capture event on comparator rise if select bit 1, else rtc/8 tick
// - capture copies counter into reload bytes and sets high flag
// - capture mode counts core clock or div12 per low-byte clock select
// - low flag set on every low byte rollover in every mode
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module timer_reload_capture
    import timer_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    // counting sources from outside the core clock
    input wire logic rtcDiv8In,
    input wire logic cmpOutIn,
    // interrupt request to the cpu
    output logic timerIrq
);
    // software-visible state
    logic [7:0] countLowHalf_ff, countHighHalf_ff, reloadLowByte_ff, reloadHighByte_ff;
    logic highOverflowFlag_ff, lowOverflowFlag_ff, lowByteIrqEnable_ff, captureEnable_ff;
    logic splitModeSelect_ff, highHalfRun_ff, lowHalfClockSelect_ff, highHalfClockSelect_ff;
    logic timerIrqEnable_ff;
    logic [1:0] externalClockSelect_ff;

    // next values
    logic [7:0] nxt_countLowHalf, nxt_countHighHalf, nxt_reloadLowByte, nxt_reloadHighByte, nxt_regRdata;
    logic nxt_highOverflowFlag, nxt_lowOverflowFlag;

    // tick sources
    logic rtcSync, cmpSync, rtcPrev_ff, cmpPrev_ff, rtcTick, cmpTick, div12Tick;

    // counting decisions
    logic lowSrcTick, highSrcTick, mode16, lowAdvance, lowWrap, highAdvance, highWrap, captureEvent;

    // bus decode
    logic wrCtrl, wrCfg, wrReloadLo, wrReloadHi, wrCountLo, wrCountHi, anyWr;

    // picks the tick for one byte from its own select and the shared code
    function automatic logic pick_tick(input logic useCore, input logic [1:0] extSel,
                                       input logic d12, input logic rtc, input logic cmp);
        logic t;
        t = 1'b0;
        if (useCore) begin
            t = 1'b1;
        end else begin
            unique case (extSel)
                EXT_DIV12: t = d12;
                EXT_RTC: t = rtc;
                EXT_CMP: t = cmp;
                EXT_RESERVED: t = 1'b0;
            endcase
        end
        return t;
    endfunction

    // address match for a write
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        return a == target;
    endfunction

    // clock sources
    sync_2ff rtcSyncer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .asyncIn(rtcDiv8In),
        .syncOut(rtcSync)
    );

    sync_2ff cmpSyncer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .asyncIn(cmpOutIn),
        .syncOut(cmpSync)
    );

    prescale_div12 div12Gen (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .tick(div12Tick)
    );

    // rising edges taken from the synchronised levels only
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rtcPrev_ff <= 1'b0;
            cmpPrev_ff <= 1'b0;
        end else if (clkEn) begin
            rtcPrev_ff <= rtcSync;
            cmpPrev_ff <= cmpSync;
        end
    end

    assign rtcTick = rtcSync & ~rtcPrev_ff;
    assign cmpTick = cmpSync & ~cmpPrev_ff;

    // bus decode
    assign wrCtrl = regWr & hit(regAddr, ADDR_CTRL);
    assign wrCfg = regWr & hit(regAddr, ADDR_CLKCFG);
    assign wrReloadLo = regWr & hit(regAddr, ADDR_RELOAD_LO);
    assign wrReloadHi = regWr & hit(regAddr, ADDR_RELOAD_HI);
    assign wrCountLo = regWr & hit(regAddr, ADDR_COUNT_LO);
    assign wrCountHi = regWr & hit(regAddr, ADDR_COUNT_HI);
    assign anyWr = regWr;

    // counting decisions
    assign lowSrcTick = pick_tick(lowHalfClockSelect_ff, externalClockSelect_ff,
                                  div12Tick, rtcTick, cmpTick);
    assign highSrcTick = pick_tick(highHalfClockSelect_ff, externalClockSelect_ff,
                                   div12Tick, rtcTick, cmpTick);
    // capture mode always uses the chained 16-bit counter
    assign mode16 = ~splitModeSelect_ff | captureEnable_ff;

    always_comb begin
        if (captureEnable_ff) begin
            lowAdvance = highHalfRun_ff & (lowHalfClockSelect_ff | div12Tick);
        end else if (splitModeSelect_ff) begin
            lowAdvance = lowSrcTick;
        end else begin
            lowAdvance = highHalfRun_ff & lowSrcTick;
        end
    end

    assign lowWrap = lowAdvance & (countLowHalf_ff == BYTE_ALL_ONES);
    assign highAdvance = mode16 ? lowWrap : (highHalfRun_ff & highSrcTick);
    assign highWrap = highAdvance & (countHighHalf_ff == BYTE_ALL_ONES);
    assign captureEvent = captureEnable_ff &
                          (externalClockSelect_ff[1] ? cmpTick : rtcTick);

    // counter bytes; a software write beats counting in the same cycle
    always_comb begin
        nxt_countLowHalf = countLowHalf_ff;
        if (wrCountLo) begin
            nxt_countLowHalf = regWdata;
        end else if (lowAdvance) begin
            if (!captureEnable_ff && (splitModeSelect_ff ? lowWrap : highWrap)) begin
                nxt_countLowHalf = reloadLowByte_ff;
            end else begin
                nxt_countLowHalf = 8'(countLowHalf_ff + 8'h01);
            end
        end
    end

    always_comb begin
        nxt_countHighHalf = countHighHalf_ff;
        if (wrCountHi) begin
            nxt_countHighHalf = regWdata;
        end else if (highAdvance) begin
            if (!captureEnable_ff && highWrap) begin
                nxt_countHighHalf = reloadHighByte_ff;
            end else begin
                nxt_countHighHalf = 8'(countHighHalf_ff + 8'h01);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            countLowHalf_ff <= BYTE_RESET;
            countHighHalf_ff <= BYTE_RESET;
        end else if (clkEn) begin
            countLowHalf_ff <= nxt_countLowHalf;
            countHighHalf_ff <= nxt_countHighHalf;
        end
    end

    // reload bytes; a capture beats a software write in the same cycle
    always_comb begin
        nxt_reloadLowByte = wrReloadLo ? regWdata : reloadLowByte_ff;
        nxt_reloadHighByte = wrReloadHi ? regWdata : reloadHighByte_ff;
        if (captureEvent) begin
            nxt_reloadLowByte = countLowHalf_ff;
            nxt_reloadHighByte = countHighHalf_ff;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reloadLowByte_ff <= BYTE_RESET;
            reloadHighByte_ff <= BYTE_RESET;
        end else if (clkEn) begin
            reloadLowByte_ff <= nxt_reloadLowByte;
            reloadHighByte_ff <= nxt_reloadHighByte;
        end
    end

    // sticky flags: hardware set wins over a software clear
    always_comb begin
        nxt_highOverflowFlag = wrCtrl ? regWdata[CTRL_HI_FLAG] : highOverflowFlag_ff;
        nxt_lowOverflowFlag = wrCtrl ? regWdata[CTRL_LO_FLAG] : lowOverflowFlag_ff;
        if ((highWrap && !captureEnable_ff) || captureEvent) begin
            nxt_highOverflowFlag = 1'b1;
        end
        if (lowWrap) begin
            nxt_lowOverflowFlag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            highOverflowFlag_ff <= 1'b0;
            lowOverflowFlag_ff <= 1'b0;
        end else if (clkEn) begin
            highOverflowFlag_ff <= nxt_highOverflowFlag;
            lowOverflowFlag_ff <= nxt_lowOverflowFlag;
        end
    end

    // control and clock configuration bits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lowByteIrqEnable_ff <= 1'b0;
            captureEnable_ff <= 1'b0;
            splitModeSelect_ff <= 1'b0;
            highHalfRun_ff <= 1'b0;
            externalClockSelect_ff <= EXT_SEL_RESET;
        end else if (clkEn && wrCtrl) begin
            lowByteIrqEnable_ff <= regWdata[CTRL_LOW_IRQ_EN];
            captureEnable_ff <= regWdata[CTRL_CAPTURE_EN];
            splitModeSelect_ff <= regWdata[CTRL_SPLIT];
            highHalfRun_ff <= regWdata[CTRL_RUN];
            externalClockSelect_ff <= regWdata[CTRL_EXT_SEL_HI:CTRL_EXT_SEL_LO];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lowHalfClockSelect_ff <= 1'b0;
            highHalfClockSelect_ff <= 1'b0;
            timerIrqEnable_ff <= 1'b0;
        end else if (clkEn && wrCfg) begin
            lowHalfClockSelect_ff <= regWdata[CFG_LOW_CLK_SEL];
            highHalfClockSelect_ff <= regWdata[CFG_HIGH_CLK_SEL];
            timerIrqEnable_ff <= regWdata[CFG_TIMER_IRQ_EN];
        end
    end

    // interrupt: one cycle behind the flags, so it stays a clean flop output
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timerIrq <= 1'b0;
        end else if (clkEn) begin
            timerIrq <= timerIrqEnable_ff &
                        (highOverflowFlag_ff | (lowByteIrqEnable_ff & lowOverflowFlag_ff));
        end
    end

    // read data stand only in the cycle after the strobe
    always_comb begin
        nxt_regRdata = BYTE_RESET;
        if (regRd) begin
            unique case (regAddr)
                ADDR_CTRL: nxt_regRdata = {highOverflowFlag_ff, lowOverflowFlag_ff,
                                           lowByteIrqEnable_ff, captureEnable_ff,
                                           splitModeSelect_ff, highHalfRun_ff,
                                           externalClockSelect_ff};
                ADDR_CLKCFG: nxt_regRdata = {5'h00, timerIrqEnable_ff,
                                             highHalfClockSelect_ff, lowHalfClockSelect_ff};
                ADDR_RELOAD_LO: nxt_regRdata = reloadLowByte_ff;
                ADDR_RELOAD_HI: nxt_regRdata = reloadHighByte_ff;
                ADDR_COUNT_LO: nxt_regRdata = countLowHalf_ff;
                ADDR_COUNT_HI: nxt_regRdata = countHighHalf_ff;
                default: nxt_regRdata = BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= BYTE_RESET;
        end else if (clkEn) begin
            regRdata <= nxt_regRdata;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_COUNT_READBACK:
    assert property (clkEn && regRd && regAddr == ADDR_COUNT_LO |=> regRdata == $past(countLowHalf_ff))
        else $error("low count read back wrong");

    AST_MODE16_RELOAD:
    assert property (clkEn && !anyWr && !splitModeSelect_ff && !captureEnable_ff && highWrap
                     |=> countHighHalf_ff == $past(reloadHighByte_ff)
                         && countLowHalf_ff == $past(reloadLowByte_ff))
        else $error("16-bit rollover did not reload");

    AST_HIGH_FLAG_SET:
    assert property (clkEn && highWrap && !captureEnable_ff |=> highOverflowFlag_ff)
        else $error("high flag not set on high rollover");

    AST_LOW_FLAG_SET:
    assert property (clkEn && lowWrap |=> lowOverflowFlag_ff)
        else $error("low flag not set on low rollover");

    AST_IRQ_FOLLOWS_FLAG:
    assert property (clkEn && timerIrqEnable_ff && highOverflowFlag_ff |=> timerIrq)
        else $error("interrupt missing for high flag");

    AST_LOW_IRQ_GATED:
    assert property (clkEn && !highOverflowFlag_ff && lowOverflowFlag_ff && !lowByteIrqEnable_ff
                     |=> !timerIrq)
        else $error("low rollover interrupt without enable");

    AST_SPLIT_HIGH_HELD:
    assert property (clkEn && !anyWr && splitModeSelect_ff && !captureEnable_ff && !highHalfRun_ff
                     |=> $stable(countHighHalf_ff))
        else $error("high byte moved with run cleared");

    AST_SPLIT_LOW_FREE:
    assert property (clkEn && !anyWr && splitModeSelect_ff && !captureEnable_ff && lowWrap
                     |=> countLowHalf_ff == $past(reloadLowByte_ff))
        else $error("split low byte did not reload");

    AST_CAPTURE_COPY:
    assert property (clkEn && captureEvent
                     |=> reloadLowByte_ff == $past(countLowHalf_ff)
                         && reloadHighByte_ff == $past(countHighHalf_ff) && highOverflowFlag_ff)
        else $error("capture did not copy counter");

    AST_FLAG_STICKY:
    assert property (clkEn && highOverflowFlag_ff && !wrCtrl |=> highOverflowFlag_ff)
        else $error("high flag cleared without software");

    AST_CORE_CLOCK_COUNT:
    assert property (clkEn && !anyWr && !splitModeSelect_ff && !captureEnable_ff && highHalfRun_ff
                     && lowHalfClockSelect_ff && countLowHalf_ff != BYTE_ALL_ONES
                     |=> countLowHalf_ff == 8'($past(countLowHalf_ff) + 8'h01))
        else $error("core clock selection did not count");
endmodule

//--- timer_pkg.sv
// constants shared by the reload/capture timer and its helpers
package timer_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // register map
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CLKCFG = 3'h1;
    localparam logic [2:0] ADDR_RELOAD_LO = 3'h2;
    localparam logic [2:0] ADDR_RELOAD_HI = 3'h3;
    localparam logic [2:0] ADDR_COUNT_LO = 3'h4;
    localparam logic [2:0] ADDR_COUNT_HI = 3'h5;
    // control register fields
    localparam int CTRL_HI_FLAG = 7;
    localparam int CTRL_LO_FLAG = 6;
    localparam int CTRL_LOW_IRQ_EN = 5;
    localparam int CTRL_CAPTURE_EN = 4;
    localparam int CTRL_SPLIT = 3;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_EXT_SEL_HI = 1;
    localparam int CTRL_EXT_SEL_LO = 0;
    // clock config register fields
    localparam int CFG_LOW_CLK_SEL = 0;
    localparam int CFG_HIGH_CLK_SEL = 1;
    localparam int CFG_TIMER_IRQ_EN = 2;
    // external clock select codes
    localparam logic [1:0] EXT_DIV12 = 2'h0;
    localparam logic [1:0] EXT_RTC = 2'h1;
    localparam logic [1:0] EXT_RESERVED = 2'h2;
    localparam logic [1:0] EXT_CMP = 2'h3;
    // reset values and counts
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [1:0] EXT_SEL_RESET = 2'h0;
    localparam logic [3:0] DIV12_LAST = 4'hb;
endpackage

//--- sync_2ff.sv
// two-stage synchroniser for a level from another clock domain
`timescale 1ns/1ns
module sync_2ff
    import timer_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            syncOut <= 1'b0;
        end else if (clkEn) begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule

//--- prescale_div12.sv
// core clock divided by twelve, as a one-cycle tick
`timescale 1ns/1ns
module prescale_div12
    import timer_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // tick out
    output logic tick
);
    logic [3:0] div_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_ff <= 4'h0;
            tick <= 1'b0;
        end else if (clkEn) begin
            div_ff <= (div_ff == DIV12_LAST) ? 4'h0 : 4'(div_ff + 4'h1);
            tick <= (div_ff == DIV12_LAST);
        end
    end
endmodule

//--- tb_timer_reload_capture.sv
// self-checking bench for the reload/capture timer
`timescale 1ns/1ns
module tb_timer_reload_capture
    import timer_pkg::*;
;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clkEn = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic rtcDiv8In = 1'b0;
    logic cmpOutIn = 1'b0;
    logic timerIrq;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'd14749;
    int mCnt, mRl, mFh, mFl;

    timer_reload_capture DUT (
        .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rtcDiv8In(rtcDiv8In), .cmpOutIn(cmpOutIn), .timerIrq(timerIrq)
    );

    always #20 core_clk = ~core_clk;

    function logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    task give_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // whole run needs about 800 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end

    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // extra edge after the strobe drops, so back-to-back calls never re-drive in one step
    task wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask

    task rd(input logic [2:0] a, output logic [7:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge core_clk);
    endtask

    // which: 0 rtc input, 1 comparator, 2 both
    task pulse(input int which);
        if (which != 1) rtcDiv8In <= 1'b1;
        if (which != 0) cmpOutIn <= 1'b1;
        repeat (4) @(posedge core_clk);
        rtcDiv8In <= 1'b0;
        cmpOutIn <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // quiet control first so capture or split mode cannot disturb the byte writes
    task setup(input logic [7:0] ctrl, input logic [15:0] cnt, input logic [15:0] rl, input logic [7:0] cfgOff);
        wr(ADDR_CLKCFG, cfgOff);
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_RELOAD_LO, rl[7:0]);
        wr(ADDR_RELOAD_HI, rl[15:8]);
        wr(ADDR_COUNT_LO, cnt[7:0]);
        wr(ADDR_COUNT_HI, cnt[15:8]);
        wr(ADDR_CTRL, ctrl);
        mCnt = cnt;
        mRl = rl;
        mFh = 0;
        mFl = 0;
    endtask

    // clock selected on for exactly n counting edges (n >= 2)
    task run_counts(input logic [7:0] cfgOn, input logic [7:0] cfgOff, input int n);
        wr(ADDR_CLKCFG, cfgOn);
        repeat (n - 2) @(posedge core_clk);
        wr(ADDR_CLKCFG, cfgOff);
    endtask

    task m16(input int n);
        repeat (n) begin
            if (mCnt == 'hffff) begin
                mCnt = mRl;
                mFh = 1;
                mFl = 1;
            end else begin
                if ((mCnt & 255) == 255) mFl = 1;
                mCnt++;
            end
        end
    endtask

    task mSplit(input int n, input int run);
        int lo;
        int hi;
        lo = mCnt & 255;
        hi = mCnt >> 8;
        repeat (n) begin
            if (lo == 255) begin
                lo = mRl & 255;
                mFl = 1;
            end else lo++;
            if (run != 0) begin
                if (hi == 255) begin
                    hi = mRl >> 8;
                    mFh = 1;
                end else hi++;
            end
        end
        mCnt = (hi << 8) | lo;
    endtask

    task check_state(input int le, input int ie);
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] c;
        rd(ADDR_COUNT_LO, lo);
        rd(ADDR_COUNT_HI, hi);
        rd(ADDR_CTRL, c);
        chk("count", {hi, lo}, mCnt[15:0]);
        chk("flags", {14'h0, c[7:6]}, 16'((mFh << 1) | mFl));
        chk("irq", {15'h0, timerIrq}, 16'(ie & (mFh | (le & mFl))));
    endtask

    initial begin
        logic [7:0] v;
        logic [7:0] w;
        logic [15:0] r;
        logic [15:0] c1;
        logic [15:0] c2;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 7; a++) begin
            rd(3'(a), v);
            chk("reset value", {8'h0, v}, 16'h0);
        end
        r = rnd();
        wr(ADDR_RELOAD_LO, r[7:0]);
        wr(ADDR_RELOAD_HI, r[15:8]);
        wr(3'h7, 8'h5a);
        rd(ADDR_RELOAD_LO, v);
        rd(ADDR_RELOAD_HI, w);
        chk("reload bytes", {w, v}, r);
        rd(3'h7, v);
        chk("unmapped", {8'h0, v}, 16'h0);
        // capture with the counter kept in 16-bit mode, core clock far faster than events
        for (int s = 0; s < 2; s++) begin
            setup(8'h14 | (s == 1 ? 8'h03 : 8'h01), 16'h0, 16'h0, 8'h04);
            wr(ADDR_CLKCFG, 8'h05);
            fork
                begin
                    repeat (5) @(posedge core_clk);
                    pulse(s);
                    repeat (52) @(posedge core_clk);
                    pulse(s);
                end
                begin
                    repeat (30) @(posedge core_clk);
                    rd(ADDR_RELOAD_LO, v);
                    rd(ADDR_RELOAD_HI, w);
                    c1 = {w, v};
                    rd(ADDR_CTRL, v);
                    chk("capture flag", {15'h0, v[7]}, 16'h1);
                    chk("capture irq", {15'h0, timerIrq}, 16'h1);
                end
            join
            repeat (6) @(posedge core_clk);
            rd(ADDR_RELOAD_LO, v);
            rd(ADDR_RELOAD_HI, w);
            c2 = {w, v};
            chk("capture period", c2 - c1, 16'd60);
        end
        // 16-bit reload: full overflow and low-byte-only rollover, low irq enable off and on
        for (int k = 0; k < 4; k++) begin
            setup(8'h06 | 8'((k & 1) << 5), (k > 1) ? 16'hfff0 : 16'h12fe, rnd(), 8'h04);
            run_counts(8'h05, 8'h04, (k > 1) ? 20 : 3);
            m16((k > 1) ? 20 : 3);
            check_state(k & 1, 1);
        end
        // split mode, run bit off then on
        for (int run = 0; run < 2; run++) begin
            setup(8'h0a | 8'(run << 2), 16'hfefc, rnd(), 8'h04);
            run_counts(8'h07, 8'h04, 6);
            mSplit(6, run);
            check_state(0, 1);
        end
        // external sources: rtc/8, reserved, comparator
        for (int e = 1; e < 4; e++) begin
            setup(8'h04 | 8'(e), 16'h0, 16'h0, 8'h04);
            repeat (5) pulse(2);
            repeat (6) @(posedge core_clk);
            wr(ADDR_CTRL, 8'h06);
            mCnt = (e == 2) ? 0 : 5;
            check_state(0, 1);
        end
        // divide-by-12 source; start phase of the divider is free, hence the window
        setup(8'h04, 16'h0, 16'h0, 8'h04);
        repeat (119) @(posedge core_clk);
        wr(ADDR_CTRL, 8'h06);
        rd(ADDR_COUNT_LO, v);
        chk("div12 count", {15'h0, (v >= 8'h09 && v <= 8'h0b)}, 16'h1);
        // clock enable low freezes the counter; only the two edges around the freeze count
        setup(8'h06, 16'h0100, 16'h0, 8'h04);
        wr(ADDR_CLKCFG, 8'h05);
        clkEn <= 1'b0;
        repeat (10) @(posedge core_clk);
        clkEn <= 1'b1;
        wr(ADDR_CLKCFG, 8'h04);
        m16(2);
        check_state(0, 1);
        give_verdict();
    end
endmodule
